//--- rtl/cpgwt_top.sv
// Cascaded 16-bit pulse generator and warm-up timer, Wishbone slave.
// Assumes classic Wishbone, 32-bit data, byte addresses; synchronous pins.
// Functional notes
// - Two bytes form one 16-bit up-counter, internal/external clock.
// - Width match inverts flop unless period also matches; counting continues.
// - Period match inverts flop in pulse mode unless width also matches; clears counter, interrupts.
// - Flop loads software initial level; reset clears it.
// - Pulse pin shows inverse of flop.
// - Compare values act immediately; keep unchanged while running.
// - Stop holds pin; initial value changed after stop.
// - Warm-up compares only period upper byte.
// - Slow warm-up: start bit, match clears, interrupts.
// - Slow warm-up 0100H..FF00H gives 7.81ms..1.99s.
// - Fast warm-up 0100H..FF00H gives 16us..4.08ms.
`timescale 1ns/10ps
module cpgwt_top
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic external_count_pin_i,
  output logic pulse_output_pin_o,
  output logic upper_timer_irq_o,
  output logic irq_o,
  output logic slow_osc_enable_o,
  output logic fast_osc_enable_o,
  output logic system_clock_select_o
);
  import cpgwt_pkg::*;

  // Prescaler mask for a divide by two to the power sel
  function automatic logic [7:0] div_mask(input logic [2:0] sel);
    div_mask = (CPGWT_PRESC_ONE << sel) - CPGWT_PRESC_ONE;
  endfunction : div_mask

  // Byte write helper honouring lane 0 strobe
  function automatic logic [7:0] byte_wr(input logic hit,
                                         input logic [7:0] old,
                                         input logic [7:0] val);
    byte_wr = hit ? val : old;
  endfunction : byte_wr

  // Software-visible state
  logic [7:0] period_reg_low_r; // Period, low byte
  logic [7:0] period_reg_high_r; // Period, high byte
  logic [7:0] width_reg_low_r; // Pulse width, low byte
  logic [7:0] width_reg_high_r; // Pulse width, high byte
  logic [3:0] lower_timer_control_r; // Clock source select
  cpgwt_upper_ctl_type upper_ctl_r; // Mode and flop initial value
  logic [1:0] status_r; // Sticky events, write one to clear
  logic [1:0] mask_r; // Interrupt enables
  logic [2:0] system_clock_control_r; // Oscillator and clock select bits

  // Counter state
  cpgwt_state_type state_r; // Stopped or running
  cpgwt_state_type state_nxt;
  logic [15:0] count_r; // Cascaded up-counter
  logic [15:0] count_nxt;
  logic [7:0] presc_r; // Free running prescaler
  logic output_flip_flop_r; // Pulse flop
  logic output_flip_flop_nxt;
  logic [1:0] status_nxt;
  logic ext_fall; // Accepted falling edge on the count pin

  // Bus request capture and decode
  cpgwt_wb_req_type req;
  assign req = '{adr: adr_i, we: we_i, sel: sel_i, dat: dat_i};
  wire bus_go = cyc_i & stb_i & ~ack_o;
  wire wr_go = bus_go & req.we & req.sel[0];
  wire [7:0] wb_byte = req.dat[7:0];
  wire wr_period_lo = wr_go & (req.adr == CPGWT_OFF_PERIOD_LO);
  wire wr_period_hi = wr_go & (req.adr == CPGWT_OFF_PERIOD_HI);
  wire wr_width_lo = wr_go & (req.adr == CPGWT_OFF_WIDTH_LO);
  wire wr_width_hi = wr_go & (req.adr == CPGWT_OFF_WIDTH_HI);
  wire wr_lower = wr_go & (req.adr == CPGWT_OFF_LOWER_CTL);
  wire wr_upper = wr_go & (req.adr == CPGWT_OFF_UPPER_CTL);
  wire wr_status = wr_go & (req.adr == CPGWT_OFF_STATUS);
  wire wr_mask = wr_go & (req.adr == CPGWT_OFF_MASK);
  wire wr_sysclk = wr_go & (req.adr == CPGWT_OFF_SYSCLK);

  // Compare values are the live registers with no shadow stage, so a
  // rewrite while running takes hold at once and can skip a match
  wire [15:0] period_val = {period_reg_high_r, period_reg_low_r};
  wire [15:0] width_val = {width_reg_high_r, width_reg_low_r};

  // Clock source and count tick
  wire running = (state_r == CPGWT_ST_RUN);
  wire ext_sel = lower_timer_control_r[CPGWT_LC_EXT_BIT];
  wire [7:0] pmask =
    div_mask(lower_timer_control_r[CPGWT_LC_DIV_MSB:CPGWT_LC_DIV_LSB]);
  wire presc_tick = ((presc_r & pmask) == pmask);
  wire tick = running & (ext_sel ? ext_fall : presc_tick);
  wire [15:0] count_inc = count_r + CPGWT_COUNT_ONE;

  // Match detection; warm-up looks at the upper byte only, so with the
  // low byte ignored the delay is period_high times 256 source ticks
  wire warm = (upper_ctl_r.mode == CPGWT_MODE_WARMUP);
  wire period_hit = warm ? (count_inc[15:8] == period_val[15:8])
                         : (count_inc == period_val);
  wire width_hit = ~warm & (count_inc == width_val);
  wire period_evt = tick & period_hit;
  wire width_evt = tick & width_hit;

  // Start edge clears the counter so each run starts from zero
  wire start_edge = (state_nxt == CPGWT_ST_RUN) & ~running;

  // Run state follows the start bit; a start is honoured in any mode,
  // oscillator readiness is left to software
  always_comb
  begin
    state_nxt = state_r;
    if (wr_upper)
    begin
      case (wb_byte[CPGWT_UC_START_BIT])
        1'b1: state_nxt = CPGWT_ST_RUN;
        default: state_nxt = CPGWT_ST_STOP;
      endcase
    end
  end

  // Counter: clear on start or period match, else count on tick
  assign count_nxt = (start_edge | period_evt) ? CPGWT_HALF_RST
                   : (tick ? count_inc : count_r);

  // Flop: loaded only by a control write made while already stopped,
  // so the stopping write itself leaves the pin where it stood
  wire flop_load = wr_upper & ~running;
  wire flop_flip = ~warm & running & (period_evt ^ width_evt);
  assign output_flip_flop_nxt =
    flop_load ? wb_byte[CPGWT_UC_INIT_BIT]
              : (output_flip_flop_r ^ flop_flip);

  // Sticky events; a new event beats a clear in the same cycle
  wire [1:0] evt_vec = {width_evt, period_evt};
  wire [1:0] clr_vec = wr_status ? wb_byte[1:0] : CPGWT_EVT_RST;
  assign status_nxt = (status_r & ~clr_vec) | evt_vec;
  wire [1:0] mask_nxt = wr_mask ? wb_byte[1:0] : mask_r;

  // Read data selection
  logic [31:0] rd_data;
  always_comb
  begin
    rd_data = CPGWT_WORD_RST;
    case (req.adr)
      CPGWT_OFF_PERIOD_LO: rd_data[7:0] = period_reg_low_r;
      CPGWT_OFF_PERIOD_HI: rd_data[7:0] = period_reg_high_r;
      CPGWT_OFF_WIDTH_LO: rd_data[7:0] = width_reg_low_r;
      CPGWT_OFF_WIDTH_HI: rd_data[7:0] = width_reg_high_r;
      CPGWT_OFF_LOWER_CTL: rd_data[3:0] = lower_timer_control_r;
      CPGWT_OFF_UPPER_CTL:
      begin
        rd_data[CPGWT_UC_MODE_BIT] = upper_ctl_r.mode;
        rd_data[CPGWT_UC_INIT_BIT] = upper_ctl_r.init;
        rd_data[CPGWT_UC_START_BIT] = running;
      end
      CPGWT_OFF_STATUS: rd_data[1:0] = status_r;
      CPGWT_OFF_MASK: rd_data[1:0] = mask_r;
      CPGWT_OFF_COUNT: rd_data[15:0] = count_r;
      CPGWT_OFF_PIN:
      begin
        rd_data[0] = output_flip_flop_r;
        rd_data[1] = pulse_output_pin_o;
      end
      CPGWT_OFF_SYSCLK: rd_data[2:0] = system_clock_control_r;
      default: rd_data = CPGWT_WORD_RST; // Unmapped reads as zero
    endcase
  end

  // External count pin filter
  cpgwt_ext_filter u_ext_filter
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(external_count_pin_i),
    .fall_o(ext_fall)
  );

  // Bus answer: one wait state, ack for one cycle, data registered
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= CPGWT_WORD_RST;
    end
    else
    begin
      ack_o <= bus_go;
      dat_o <= bus_go ? rd_data : CPGWT_WORD_RST;
    end
  end

  // Compare registers; byte order is left to software
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      period_reg_low_r <= CPGWT_BYTE_RST;
      period_reg_high_r <= CPGWT_BYTE_RST;
      width_reg_low_r <= CPGWT_BYTE_RST;
      width_reg_high_r <= CPGWT_BYTE_RST;
    end
    else
    begin
      period_reg_low_r <= byte_wr(wr_period_lo, period_reg_low_r, wb_byte);
      period_reg_high_r <= byte_wr(wr_period_hi, period_reg_high_r, wb_byte);
      width_reg_low_r <= byte_wr(wr_width_lo, width_reg_low_r, wb_byte);
      width_reg_high_r <= byte_wr(wr_width_hi, width_reg_high_r, wb_byte);
    end
  end

  // Control registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lower_timer_control_r <= CPGWT_BYTE_RST[3:0];
      upper_ctl_r <= '{init: 1'b0, mode: CPGWT_MODE_PULSE};
      system_clock_control_r <= CPGWT_SYSCLK_RST;
    end
    else
    begin
      if (wr_lower)
      begin
        lower_timer_control_r <= wb_byte[3:0];
      end
      if (wr_upper)
      begin
        upper_ctl_r.init <= wb_byte[CPGWT_UC_INIT_BIT];
        upper_ctl_r.mode <= cpgwt_mode_type'(wb_byte[CPGWT_UC_MODE_BIT]);
      end
      if (wr_sysclk)
      begin
        system_clock_control_r <= wb_byte[2:0];
      end
    end
  end

  // Counter, prescaler and run state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= CPGWT_ST_STOP;
      count_r <= CPGWT_HALF_RST;
      presc_r <= CPGWT_BYTE_RST;
    end
    else
    begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      presc_r <= presc_r + CPGWT_PRESC_ONE;
    end
  end

  // Flop, pin, events and interrupt outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      output_flip_flop_r <= 1'b0;
      pulse_output_pin_o <= 1'b1;
      status_r <= CPGWT_EVT_RST;
      mask_r <= CPGWT_EVT_RST;
      upper_timer_irq_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      output_flip_flop_r <= output_flip_flop_nxt;
      pulse_output_pin_o <= ~output_flip_flop_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      upper_timer_irq_o <= period_evt;
      irq_o <= |(status_nxt & mask_nxt);
    end
  end

  // Oscillator and system clock select outputs
  assign slow_osc_enable_o = system_clock_control_r[CPGWT_SC_SLOW_BIT];
  assign fast_osc_enable_o = system_clock_control_r[CPGWT_SC_FAST_BIT];
  assign system_clock_select_o = system_clock_control_r[CPGWT_SC_SEL_BIT];

endmodule : cpgwt_top

//--- common/cpgwt_pkg.sv
// Package for the cascaded pulse generator and warm-up timer.
// Holds register offsets, field positions, reset values and carrier types.
// Assumes a classic Wishbone slave with byte addresses, one word per register.
package cpgwt_pkg;

  // Register byte offsets, one aligned 32-bit word each
  localparam logic [7:0] CPGWT_OFF_PERIOD_LO = 8'h00;
  localparam logic [7:0] CPGWT_OFF_PERIOD_HI = 8'h04;
  localparam logic [7:0] CPGWT_OFF_WIDTH_LO = 8'h08;
  localparam logic [7:0] CPGWT_OFF_WIDTH_HI = 8'h0C;
  localparam logic [7:0] CPGWT_OFF_LOWER_CTL = 8'h10;
  localparam logic [7:0] CPGWT_OFF_UPPER_CTL = 8'h14;
  localparam logic [7:0] CPGWT_OFF_STATUS = 8'h18;
  localparam logic [7:0] CPGWT_OFF_MASK = 8'h1C;
  localparam logic [7:0] CPGWT_OFF_COUNT = 8'h20;
  localparam logic [7:0] CPGWT_OFF_PIN = 8'h24;
  localparam logic [7:0] CPGWT_OFF_SYSCLK = 8'h28;

  // Lower timer control fields
  localparam int CPGWT_LC_DIV_LSB = 0;
  localparam int CPGWT_LC_DIV_MSB = 2;
  localparam int CPGWT_LC_EXT_BIT = 3;

  // Upper timer control fields
  localparam int CPGWT_UC_MODE_BIT = 0;
  localparam int CPGWT_UC_INIT_BIT = 1;
  localparam int CPGWT_UC_START_BIT = 2;

  // System clock control fields
  localparam int CPGWT_SC_SLOW_BIT = 0;
  localparam int CPGWT_SC_FAST_BIT = 1;
  localparam int CPGWT_SC_SEL_BIT = 2;

  // Status and mask fields
  localparam int CPGWT_ST_PERIOD_BIT = 0;
  localparam int CPGWT_ST_WIDTH_BIT = 1;

  // Reset values and unit increment constants
  localparam logic [7:0] CPGWT_BYTE_RST = 8'h00;
  localparam logic [15:0] CPGWT_HALF_RST = 16'h0000;
  localparam logic [31:0] CPGWT_WORD_RST = 32'h0000_0000;
  localparam logic [15:0] CPGWT_COUNT_ONE = 16'h0001;
  localparam logic [7:0] CPGWT_PRESC_ONE = 8'h01;
  localparam logic [2:0] CPGWT_SYSCLK_RST = 3'h2;
  localparam logic [1:0] CPGWT_EVT_RST = 2'h0;

  // Least high or low time of the external count input, in cycles
  localparam int CPGWT_EXT_HOLD_CYC = 2;

  // Run state of the cascaded counter
  typedef enum logic [1:0]
  {
    CPGWT_ST_STOP = 2'b00,
    CPGWT_ST_RUN = 2'b01
  } cpgwt_state_type;

  // Operating mode
  typedef enum logic
  {
    CPGWT_MODE_PULSE = 1'b0,
    CPGWT_MODE_WARMUP = 1'b1
  } cpgwt_mode_type;

  // One Wishbone request as captured from the bus
  typedef struct packed
  {
    logic [7:0] adr;
    logic we;
    logic [3:0] sel;
    logic [31:0] dat;
  } cpgwt_wb_req_type;

  // Upper timer control contents
  typedef struct packed
  {
    logic init;
    cpgwt_mode_type mode;
  } cpgwt_upper_ctl_type;

endpackage : cpgwt_pkg

//--- rtl/cpgwt_ext_filter.sv
// External count input filter for the cascaded timer.
// Accepts a level only after it has stood for the least hold time and
// gives a one-cycle pulse on each accepted falling edge.
// Assumes the pin is already synchronous to clk_i.
`timescale 1ns/10ps
module cpgwt_ext_filter
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic fall_o
);
  import cpgwt_pkg::*;

  logic [CPGWT_EXT_HOLD_CYC-1:0] hist_r; // Recent pin samples
  logic level_r; // Accepted level
  logic level_nxt;
  wire all_low = ~(|hist_r);
  wire all_high = &hist_r;

  // Shorter glitches leave the accepted level alone
  assign level_nxt = all_low ? 1'b0 : (all_high ? 1'b1 : level_r);

  // Sample history, accepted level, edge pulse
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hist_r <= '1;
      level_r <= 1'b1;
      fall_o <= 1'b0;
    end
    else
    begin
      hist_r <= {hist_r[CPGWT_EXT_HOLD_CYC-2:0], pin_i};
      level_r <= level_nxt;
      fall_o <= level_r & ~level_nxt;
    end
  end

endmodule : cpgwt_ext_filter

//--- verification/cpgwt_chk.sv
// Port-level assertion checker for the cascaded timer.
// Assumes one clock and the synchronous active-high reset of the top.
`timescale 1ns/10ps
module cpgwt_chk
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic pulse_output_pin_o,
  input wire logic upper_timer_irq_o,
  input wire logic irq_o,
  input wire logic slow_osc_enable_o,
  input wire logic fast_osc_enable_o,
  input wire logic system_clock_select_o
);
  // Request still waiting for its answer
  wire logic req_wait;
  // Clock control outputs as one group
  wire logic [2:0] sys_bits;
  assign req_wait = cyc_i & stb_i & ~ack_o;
  assign sys_bits = {system_clock_select_o, fast_osc_enable_o,
                     slow_osc_enable_o};

  a_ack_follows_req:
  assert property (@(posedge clk_i) disable iff (rst_i) req_wait |=> ack_o)
    else $error("ack missing one cycle after request");
  a_ack_one_cycle:
  assert property (@(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_dat_idle_zero:
  assert property (@(posedge clk_i) disable iff (rst_i)
    !ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data outside ack cycle");
  a_irq_single_pulse:
  assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(upper_timer_irq_o) |=> !upper_timer_irq_o [*2])
    else $error("timer interrupt wider than one cycle");
  a_pin_after_reset:
  assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> pulse_output_pin_o)
    else $error("pin not high after reset");
  a_osc_after_reset:
  assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> sys_bits == 3'h2)
    else $error("clock control wrong after reset");
  a_irq_after_reset:
  assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> !irq_o && !upper_timer_irq_o)
    else $error("interrupt active after reset");
  a_sys_by_write:
  assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && $changed(sys_bits) |-> ack_o && $past(we_i))
    else $error("clock control changed without a write");
endmodule : cpgwt_chk

bind cpgwt_top cpgwt_chk i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o),
  .pulse_output_pin_o(pulse_output_pin_o),
  .upper_timer_irq_o(upper_timer_irq_o), .irq_o(irq_o),
  .slow_osc_enable_o(slow_osc_enable_o),
  .fast_osc_enable_o(fast_osc_enable_o),
  .system_clock_select_o(system_clock_select_o));

//--- verification/cpgwt_tb.sv
// Self-checking bench for the cascaded timer over classic Wishbone.
// Assumes the package offsets and a one-cycle registered ack.
`timescale 1ns/10ps
module cpgwt_tb;
  import cpgwt_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0000_0000;
  logic ext_i = 1'b1;
  logic [31:0] dat_o;
  logic ack_o, pin_o, tirq_o, irq_o, slow_o, fast_o, sel_o;
  int fail_count = 0;
  int checks_done = 0;
  int n;
  int m;
  logic p;
  logic [31:0] rd;

  // Free-running 50 MHz clock
  always #10 clk_i = ~clk_i;

  cpgwt_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .external_count_pin_i(ext_i), .pulse_output_pin_o(pin_o),
    .upper_timer_irq_o(tirq_o), .irq_o(irq_o), .slow_osc_enable_o(slow_o),
    .fast_osc_enable_o(fast_o), .system_clock_select_o(sel_o));

  task close_out;
    if (fail_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  // A wait that ran out ends the run
  task hang;
    $display("BAD %0t wait ran out", $time);
    fail_count++;
    close_out();
  endtask : hang

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("BAD %0t got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  // Holds the request until ack is sampled, then releases for one cycle
  task bus(input logic [7:0] a, input logic w, input logic [7:0] d,
           output logic [31:0] q);
    int k;
    k = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h00_0000, d};
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack_o !== 1'b1 && k < 50);
    if (k >= 50)
      hang();
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d, rd);
  endtask : wr

  // Cycles until the next timer interrupt pulse
  task gap(output int g);
    g = 0;
    do
    begin
      @(posedge clk_i);
      g++;
    end
    while (tirq_o !== 1'b1 && g < 2000);
    if (g >= 2000)
      hang();
  endtask : gap

  // Counts interrupt pulses and pin changes over k cycles
  task run(input int k, output int np, output int nc);
    np = 0;
    nc = 0;
    p = pin_o;
    repeat (k)
    begin
      @(posedge clk_i);
      np += (tirq_o === 1'b1);
      nc += (pin_o !== p);
      p = pin_o;
    end
  endtask : run

  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'(pin_o), 32'h0000_0001);
    bus(CPGWT_OFF_SYSCLK, 1'b0, 8'h00, rd);
    chk(rd, 32'h0000_0002);
    bus(8'h30, 1'b0, 8'h00, rd);
    chk(rd, 32'h0000_0000);
    // Period 3, width 1, tick every clock
    wr(CPGWT_OFF_PERIOD_LO, 8'h03);
    wr(CPGWT_OFF_PERIOD_HI, 8'h00);
    wr(CPGWT_OFF_WIDTH_LO, 8'h01);
    wr(CPGWT_OFF_WIDTH_HI, 8'h00);
    bus(CPGWT_OFF_PERIOD_LO, 1'b0, 8'h00, rd);
    chk(rd, 32'h0000_0003);
    wr(CPGWT_OFF_MASK, 8'h01);
    wr(CPGWT_OFF_UPPER_CTL, 8'h04);
    repeat (12) @(posedge clk_i);
    run(30, n, m);
    chk(32'(n), 32'h0000_000A);
    chk(32'(m), 32'h0000_0014);
    chk(32'(irq_o), 32'h0000_0001);
    // Stop holds the pin, then a stopped write loads the flop
    wr(CPGWT_OFF_UPPER_CTL, 8'h00);
    p = pin_o;
    repeat (10) @(posedge clk_i);
    chk(32'(pin_o), 32'(p));
    wr(CPGWT_OFF_UPPER_CTL, 8'h02);
    bus(CPGWT_OFF_PIN, 1'b0, 8'h00, rd);
    chk(rd, 32'h0000_0001);
    wr(CPGWT_OFF_STATUS, 8'h03);
    bus(CPGWT_OFF_STATUS, 1'b0, 8'h00, rd);
    chk(rd, 32'h0000_0000);
    chk(32'(irq_o), 32'h0000_0000);
    // Slow warm-up ignores the low period byte; slow oscillator goes first
    wr(CPGWT_OFF_SYSCLK, 8'h03);
    wr(CPGWT_OFF_PERIOD_LO, 8'hFF);
    wr(CPGWT_OFF_PERIOD_HI, 8'h01);
    wr(CPGWT_OFF_UPPER_CTL, 8'h05);
    gap(n);
    gap(n);
    chk(32'(n), 32'h0000_0100);
    chk(32'(pin_o), 32'h0000_0001);
    // Stop, select the slow clock, then turn the fast oscillator off
    wr(CPGWT_OFF_UPPER_CTL, 8'h00);
    wr(CPGWT_OFF_SYSCLK, 8'h07);
    wr(CPGWT_OFF_SYSCLK, 8'h05);
    chk(32'({sel_o, fast_o, slow_o}), 32'h0000_0005);
    // Prescaler divides by four
    wr(CPGWT_OFF_UPPER_CTL, 8'h00);
    wr(CPGWT_OFF_LOWER_CTL, 8'h02);
    wr(CPGWT_OFF_PERIOD_LO, 8'h03);
    wr(CPGWT_OFF_PERIOD_HI, 8'h00);
    wr(CPGWT_OFF_UPPER_CTL, 8'h04);
    gap(n);
    gap(n);
    chk(32'(n), 32'h0000_000C);
    // External input, three-cycle levels, six falling edges
    wr(CPGWT_OFF_UPPER_CTL, 8'h00);
    wr(CPGWT_OFF_LOWER_CTL, 8'h08);
    wr(CPGWT_OFF_UPPER_CTL, 8'h04);
    n = 0;
    for (int i = 0; i < 48; i++)
    begin
      ext_i <= !(i < 36 && i % 6 >= 3);
      @(posedge clk_i);
      n += (tirq_o === 1'b1);
    end
    chk(32'(n), 32'h0000_0002);
    // Fast warm-up: oscillator on before start, then switch back
    wr(CPGWT_OFF_UPPER_CTL, 8'h00);
    wr(CPGWT_OFF_SYSCLK, 8'h07);
    wr(CPGWT_OFF_LOWER_CTL, 8'h00);
    wr(CPGWT_OFF_PERIOD_LO, 8'h00);
    wr(CPGWT_OFF_PERIOD_HI, 8'h01);
    wr(CPGWT_OFF_UPPER_CTL, 8'h05);
    gap(n);
    gap(n);
    chk(32'(n), 32'h0000_0100);
    wr(CPGWT_OFF_UPPER_CTL, 8'h00);
    wr(CPGWT_OFF_SYSCLK, 8'h03);
    wr(CPGWT_OFF_SYSCLK, 8'h02);
    chk(32'({sel_o, fast_o, slow_o}), 32'h0000_0002);
    close_out();
  end
endmodule : cpgwt_tb
